// ### src/csl_link.sv
// csl_link: half-duplex asynchronous character link with Avalon-MM registers
// assumes RXD comes from a pin (synchronised here) and a single 10 MHz clock
`timescale 1ns/10ps
// Operation
// - Counter and host never transmit together; each waits for the other's frame to end.
// - Bit rate is one of 2400, 4800, 9600 or 19200 bps, equal at both ends.
// - Each character starts with exactly one start bit.
// - Each character ends with exactly one stop bit.
// - A character carries seven or eight data bits, equal at both ends.
// - Parity is none, odd or even; the sender appends it and the receiver checks it.
// - All frame content is ASCII codes, checksum included.
// - Rate, data length, parity and station number come from the counter's configuration.
// - Setpoint writes over the link are accepted only when the setpoint source is serial.
// - The checksum covers every character from the '@' header up to the first checksum character.
// - The checksum is the low byte of the code sum, sent as two ASCII hex digits, high first.
// - The response status is two ASCII hex characters: 00 normal, 01 communication fault.
module csl_link #(
	parameter int BIT_CYC_2400 = csl_pkg::CYC_2400
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// avalon-mm slave
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// serial line
	input wire logic RXD,
	output logic TXD,
	output logic TX_EN,
	// system
	output logic IRQ,
	output logic SETPOINT_WR_EN
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] hex_ascii(input logic [3:0] nib);
		hex_ascii = (nib < 4'hA) ? 8'(8'h30 + nib) : 8'(8'h37 + nib);
	endfunction : hex_ascii

	function automatic logic par_bit(input logic [7:0] d, input logic [1:0] mode);
		par_bit = (mode == csl_pkg::PAR_ODD) ? ~^d : ^d;
	endfunction : par_bit

	localparam int ST_W_L = csl_pkg::ST_W - 1;
	csl_pkg::csl_ctrl_s ctrl;
	logic [ST_W_L:0] stat;
	logic [ST_W_L:0] mask;
	logic [ST_W_L:0] stat_set;
	logic ack;
	logic acc_wr;
	logic acc_rd;
	logic tx_go;
	logic [12:0] bit_cyc;
	logic [7:0] dmask;
	logic has_par;
	csl_pkg::csl_state_e tx_st;
	csl_pkg::csl_state_e rx_st;
	logic [12:0] tx_cnt;
	logic [12:0] rx_cnt;
	logic [2:0] tx_idx;
	logic [2:0] rx_idx;
	logic [7:0] tx_sh;
	logic [7:0] rx_sh;
	logic tx_par;
	logic [7:0] rx_data;
	logic [7:0] tx_sum;
	logic [7:0] rx_sum;
	logic [7:0] rx_sum_p1;
	logic [7:0] rx_sum_p2;
	logic [7:0] ch_p1;
	logic [7:0] ch_p2;
	logic fault;
	logic rxd_m;
	logic rxd_s;
	logic rx_done;
	logic [7:0] rx_char;

	// ----------------------------------------
	// configuration decode
	// ----------------------------------------
	// bit time and character shape follow the configuration register
	always_comb begin
		case (ctrl.baud)
			2'h0: bit_cyc = 13'(BIT_CYC_2400);
			2'h1: bit_cyc = 13'(csl_pkg::CYC_4800);
			2'h2: bit_cyc = 13'(csl_pkg::CYC_9600);
			default: bit_cyc = 13'(csl_pkg::CYC_19200);
		endcase
	end
	assign dmask = ctrl.data8 ? 8'hFF : 8'h7F;
	assign has_par = (ctrl.parity == csl_pkg::PAR_ODD) || (ctrl.parity == csl_pkg::PAR_EVEN);
	assign SETPOINT_WR_EN = ctrl.sp_serial;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	// a tx data write waits while either direction is busy
	assign tx_go = (AVS_ADDRESS == csl_pkg::OFS_TXDATA) && (tx_st != csl_pkg::S_IDLE || rx_st != csl_pkg::S_IDLE);
	// a tx write that finds the receiver newly busy keeps waiting
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~(ack & ~(AVS_WRITE & tx_go));
	assign acc_wr = AVS_WRITE & ack & ~tx_go;
	assign acc_rd = AVS_READ & ~ack;

	// one wait cycle per access, longer for a blocked tx write
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ack <= 1'b0;
		end else begin
			ack <= (AVS_READ | AVS_WRITE) & ~ack & ~(AVS_WRITE & tx_go);
		end
	end

	// read data captured on the edge that ends the wait
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			AVS_READDATA <= 32'h0;
		end else if (acc_rd) begin
			if (AVS_ADDRESS == csl_pkg::OFS_CTRL) begin
				AVS_READDATA <= {16'h0, ctrl};
			end else if (AVS_ADDRESS == csl_pkg::OFS_STAT) begin
				AVS_READDATA <= {26'h0, stat};
			end else if (AVS_ADDRESS == csl_pkg::OFS_MASK) begin
				AVS_READDATA <= {26'h0, mask};
			end else if (AVS_ADDRESS == csl_pkg::OFS_RXDATA) begin
				AVS_READDATA <= {24'h0, rx_data};
			end else if (AVS_ADDRESS == csl_pkg::OFS_CKSUM) begin
				AVS_READDATA <= {hex_ascii(rx_sum[7:4]), hex_ascii(rx_sum[3:0]),
					hex_ascii(tx_sum[7:4]), hex_ascii(tx_sum[3:0])};
			end else if (AVS_ADDRESS == csl_pkg::OFS_RESP) begin
				AVS_READDATA <= {16'h0, csl_pkg::CH_ZERO, fault ? csl_pkg::CH_ONE : csl_pkg::CH_ZERO};
			end else begin
				AVS_READDATA <= 32'h0;
			end
		end
	end

	// configuration and mask registers
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			ctrl <= csl_pkg::CTRL_RST;
			mask <= '0;
		end else if (acc_wr) begin
			if (AVS_ADDRESS == csl_pkg::OFS_CTRL) begin
				if (AVS_BYTEENABLE[0]) begin
					ctrl[7:0] <= {2'h0, AVS_WRITEDATA[5:0]};
				end
				if (AVS_BYTEENABLE[1]) begin
					ctrl.station_id <= AVS_WRITEDATA[15:8];
				end
			end else if (AVS_ADDRESS == csl_pkg::OFS_MASK && AVS_BYTEENABLE[0]) begin
				mask <= AVS_WRITEDATA[ST_W_L:0];
			end
		end
	end

	// sticky status, write one to clear, a new event wins over the clear
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			stat <= '0;
		end else if (acc_wr && AVS_ADDRESS == csl_pkg::OFS_STAT && AVS_BYTEENABLE[0]) begin
			stat <= (stat & ~AVS_WRITEDATA[ST_W_L:0]) | stat_set;
		end else begin
			stat <= stat | stat_set;
		end
	end
	assign IRQ = |(stat & mask);

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	// start, data lsb first, optional parity, one stop
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tx_st <= csl_pkg::S_IDLE;
			TXD <= 1'b1;
			tx_cnt <= '0;
			tx_idx <= '0;
			tx_sh <= '0;
			tx_par <= 1'b0;
		end else if (tx_st == csl_pkg::S_IDLE) begin
			TXD <= 1'b1;
			if (acc_wr && AVS_ADDRESS == csl_pkg::OFS_TXDATA) begin
				tx_st <= csl_pkg::S_START;
				TXD <= 1'b0;
				tx_cnt <= 13'(bit_cyc - 13'h1);
				tx_sh <= AVS_WRITEDATA[7:0] & dmask;
				tx_par <= par_bit(AVS_WRITEDATA[7:0] & dmask, ctrl.parity);
				tx_idx <= '0;
			end
		end else if (tx_cnt != 13'h0) begin
			tx_cnt <= 13'(tx_cnt - 13'h1);
		end else begin
			tx_cnt <= 13'(bit_cyc - 13'h1);
			case (tx_st)
				csl_pkg::S_START: begin
					tx_st <= csl_pkg::S_DATA;
					TXD <= tx_sh[0];
				end
				csl_pkg::S_DATA: begin
					tx_sh <= {1'b0, tx_sh[7:1]};
					tx_idx <= 3'(tx_idx + 3'h1);
					if (tx_idx == (ctrl.data8 ? 3'h7 : 3'h6)) begin
						tx_st <= has_par ? csl_pkg::S_PAR : csl_pkg::S_STOP;
						TXD <= has_par ? tx_par : 1'b1;
					end else begin
						TXD <= tx_sh[1];
					end
				end
				csl_pkg::S_PAR: begin
					tx_st <= csl_pkg::S_STOP;
					TXD <= 1'b1;
				end
				default: begin
					tx_st <= csl_pkg::S_IDLE;
					TXD <= 1'b1;
				end
			endcase
		end
	end
	assign TX_EN = (tx_st != csl_pkg::S_IDLE);

	// transmit checksum restarts at the header
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tx_sum <= '0;
		end else if (acc_wr && AVS_ADDRESS == csl_pkg::OFS_TXDATA) begin
			if ((AVS_WRITEDATA[7:0] & dmask) == csl_pkg::CH_HEAD) begin
				tx_sum <= csl_pkg::CH_HEAD;
			end else begin
				tx_sum <= 8'(tx_sum + (AVS_WRITEDATA[7:0] & dmask));
			end
		end
	end

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	// two-flop synchroniser on the line
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rxd_m <= 1'b1;
			rxd_s <= 1'b1;
		end else begin
			rxd_m <= RXD;
			rxd_s <= rxd_m;
		end
	end

	// the line is ignored while this end transmits
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rx_st <= csl_pkg::S_IDLE;
			rx_cnt <= '0;
			rx_idx <= '0;
			rx_sh <= '0;
			rx_data <= '0;
		end else if (rx_st == csl_pkg::S_IDLE) begin
			if (!rxd_s && tx_st == csl_pkg::S_IDLE && !(acc_wr && AVS_ADDRESS == csl_pkg::OFS_TXDATA)) begin
				rx_st <= csl_pkg::S_START;
				rx_cnt <= {1'b0, bit_cyc[12:1]}; // sample mid-bit
			end
		end else if (rx_cnt != 13'h0) begin
			rx_cnt <= 13'(rx_cnt - 13'h1);
		end else begin
			rx_cnt <= 13'(bit_cyc - 13'h1);
			case (rx_st)
				csl_pkg::S_START: begin
					rx_st <= rxd_s ? csl_pkg::S_IDLE : csl_pkg::S_DATA;
					rx_idx <= '0;
					rx_sh <= '0;
				end
				csl_pkg::S_DATA: begin
					rx_idx <= 3'(rx_idx + 3'h1);
					rx_sh <= ctrl.data8 ? {rxd_s, rx_sh[7:1]} : {1'b0, rxd_s, rx_sh[6:1]};
					if (rx_idx == (ctrl.data8 ? 3'h7 : 3'h6)) begin
						rx_st <= has_par ? csl_pkg::S_PAR : csl_pkg::S_STOP;
					end
				end
				csl_pkg::S_PAR: rx_st <= csl_pkg::S_STOP;
				default: begin
					rx_st <= csl_pkg::S_IDLE;
					rx_data <= rx_sh;
				end
			endcase
		end
	end

	// character events; parity is checked against the sampled bit
	logic rx_tick;
	assign rx_tick = (rx_cnt == 13'h0) && (rx_st != csl_pkg::S_IDLE);
	assign rx_done = rx_tick && rx_st == csl_pkg::S_STOP;
	assign rx_char = rx_sh & dmask;
	always_comb begin
		stat_set = '0;
		stat_set[csl_pkg::ST_RX_DONE] = rx_done;
		stat_set[csl_pkg::ST_TX_DONE] = (tx_st == csl_pkg::S_STOP) && (tx_cnt == 13'h0);
		stat_set[csl_pkg::ST_FRAME_ERR] = rx_done && !rxd_s;
		stat_set[csl_pkg::ST_PAR_ERR] = rx_tick && rx_st == csl_pkg::S_PAR
			&& (rxd_s != par_bit(rx_char, ctrl.parity));
		stat_set[csl_pkg::ST_SUM_OK] = rx_done && rxd_s && rx_char == csl_pkg::CH_CR
			&& ch_p2 == hex_ascii(rx_sum_p2[7:4]) && ch_p1 == hex_ascii(rx_sum_p2[3:0]);
		stat_set[csl_pkg::ST_SUM_BAD] = rx_done && rxd_s && rx_char == csl_pkg::CH_CR
			&& !(ch_p2 == hex_ascii(rx_sum_p2[7:4]) && ch_p1 == hex_ascii(rx_sum_p2[3:0]));
	end

	// receive checksum and history, restarted by the header
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			rx_sum <= '0;
			rx_sum_p1 <= '0;
			rx_sum_p2 <= '0;
			ch_p1 <= '0;
			ch_p2 <= '0;
		end else if (rx_done && rxd_s) begin
			rx_sum <= (rx_char == csl_pkg::CH_HEAD) ? csl_pkg::CH_HEAD : 8'(rx_sum + rx_char);
			rx_sum_p1 <= rx_sum;
			rx_sum_p2 <= rx_sum_p1;
			ch_p1 <= rx_char;
			ch_p2 <= ch_p1;
		end
	end

	// communication fault for the response status, cleared by a new header
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			fault <= 1'b0;
		end else if (stat_set[csl_pkg::ST_FRAME_ERR] || stat_set[csl_pkg::ST_PAR_ERR]
			|| stat_set[csl_pkg::ST_SUM_BAD]) begin
			fault <= 1'b1;
		end else if (rx_done && rx_char == csl_pkg::CH_HEAD) begin
			fault <= 1'b0;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence stop_low_s;
		rx_done && !rxd_s;
	endsequence
	AST_HALF_DUPLEX: assert property (@(posedge CLK) disable iff (RESET)
		!(tx_st != csl_pkg::S_IDLE && rx_st != csl_pkg::S_IDLE)) else $error("tx and rx active together");
	AST_BIT_TIME: assert property (@(posedge CLK) disable iff (RESET)
		($past(tx_st) != csl_pkg::S_IDLE && tx_st != $past(tx_st)) |-> $past(tx_cnt) == 13'h0)
		else $error("tx bit ended early");
	AST_START_LOW: assert property (@(posedge CLK) disable iff (RESET)
		tx_st == csl_pkg::S_START |-> !TXD) else $error("start bit not low");
	AST_STOP_HIGH: assert property (@(posedge CLK) disable iff (RESET)
		tx_st == csl_pkg::S_STOP |-> TXD) else $error("stop bit not high");
	AST_DATA_LEN: assert property (@(posedge CLK) disable iff (RESET)
		($past(tx_st) == csl_pkg::S_DATA && tx_st != csl_pkg::S_DATA)
		|-> $past(tx_idx) == (ctrl.data8 ? 3'h7 : 3'h6)) else $error("wrong data bit count");
	AST_PARITY: assert property (@(posedge CLK) disable iff (RESET)
		tx_st == csl_pkg::S_PAR |-> TXD == tx_par && has_par) else $error("parity bit wrong");
	AST_IDLE_MARK: assert property (@(posedge CLK) disable iff (RESET)
		tx_st == csl_pkg::S_IDLE |-> ##1 (tx_st != csl_pkg::S_IDLE || TXD)) else $error("idle line not mark");
	AST_FRAME_ERR: assert property (@(posedge CLK) disable iff (RESET)
		stop_low_s |-> ##1 stat[csl_pkg::ST_FRAME_ERR] && fault) else $error("framing error lost");
endmodule : csl_link

// ### inc/csl_pkg.sv
// csl_pkg: constants and types of the counter serial link
// assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus
package csl_pkg;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int BAUD_2400 = 2400;
	localparam int BAUD_4800 = 4800;
	localparam int BAUD_9600 = 9600;
	localparam int BAUD_19200 = 19200;
	localparam int CYC_2400 = CLK_HZ / BAUD_2400;
	localparam int CYC_4800 = CLK_HZ / BAUD_4800;
	localparam int CYC_9600 = CLK_HZ / BAUD_9600;
	localparam int CYC_19200 = CLK_HZ / BAUD_19200;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_STAT = 5'h04;
	localparam logic [4:0] OFS_MASK = 5'h08;
	localparam logic [4:0] OFS_TXDATA = 5'h0C;
	localparam logic [4:0] OFS_RXDATA = 5'h10;
	localparam logic [4:0] OFS_CKSUM = 5'h14;
	localparam logic [4:0] OFS_RESP = 5'h18;
	// ----------------------------------------
	// status bit positions and reset values
	// ----------------------------------------
	localparam int ST_RX_DONE = 0;
	localparam int ST_TX_DONE = 1;
	localparam int ST_FRAME_ERR = 2;
	localparam int ST_PAR_ERR = 3;
	localparam int ST_SUM_OK = 4;
	localparam int ST_SUM_BAD = 5;
	localparam int ST_W = 6;
	localparam logic [15:0] CTRL_RST = 16'h0100;
	// ----------------------------------------
	// codes
	// ----------------------------------------
	localparam logic [7:0] CH_HEAD = 8'h40;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_ONE = 8'h31;
	localparam logic [1:0] PAR_ODD = 2'h1;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_START = 3'h1, S_DATA = 3'h3, S_PAR = 3'h2, S_STOP = 3'h6
	} csl_state_e;
	typedef struct packed {
		logic [7:0] station_id;
		logic [1:0] unused;
		logic sp_serial;
		logic [1:0] parity;
		logic data8;
		logic [1:0] baud;
	} csl_ctrl_s;
endpackage : csl_pkg

// ### sim/csl_host.sv
// csl_host: behavioural host computer on the far side of the serial line
// assumes bit times are handed over in system clock cycles
`timescale 1ns/10ps
module csl_host (
	// clock
	input wire logic CLK,
	// serial line
	input wire logic TXD,
	input wire logic TX_EN,
	output logic RXD
);
	logic busy = 1'b0;
	logic overlap = 1'b0;
	// line rests at mark outside host frames
	initial RXD = 1'b1;
	// flag any counter transmission while the host owns the line
	always @(posedge CLK) if (busy && TX_EN) overlap <= 1'b1;
	// send one character; bad_par and bad_stop break the frame on purpose
	task automatic send(input logic [7:0] d, input int nd, input logic [1:0] par, input int bc,
		input logic bad_par, input logic bad_stop);
		logic [11:0] q;
		logic [7:0] dm;
		int nb;
		@(posedge CLK);
		while (TX_EN !== 1'b0) @(posedge CLK);
		dm = (nd == 8) ? d : {1'b0, d[6:0]};
		q = 12'h000;
		for (int k = 0; k < nd; k++) q[k + 1] = dm[k];
		nb = nd + 1;
		if (par == 2'h1 || par == 2'h2) begin
			q[nb] = (^dm) ^ (par == 2'h1) ^ bad_par;
			nb++;
		end
		q[nb] = ~bad_stop;
		nb++;
		busy <= 1'b1;
		for (int k = 0; k < nb; k++) begin
			RXD <= q[k];
			repeat (k == nb - 1 ? bc / 2 : bc) @(posedge CLK);
		end
		busy <= 1'b0;
		repeat (bc - bc / 2) @(posedge CLK);
		RXD <= 1'b1;
	endtask : send
	// sample one counter character mid-bit and time the whole frame
	task automatic recv(input int nb, input int bc, output logic [11:0] bits, output int len);
		len = 0;
		bits = 12'h000;
		while (TXD !== 1'b0 && len < 60000) begin
			@(posedge CLK);
			len++;
		end
		for (int k = 0; k < nb; k++) begin
			repeat (k == 0 ? bc / 2 : bc) @(posedge CLK);
			bits[k] = TXD;
		end
		len = bc / 2 + (nb - 1) * bc;
		while (TX_EN === 1'b1 && len < 60000) begin
			@(posedge CLK);
			len++;
		end
	endtask : recv
endmodule : csl_host

// ### sim/tb.sv
// tb: self-checking bench of the counter serial link
// assumes csl_pkg and csl_host are compiled before it
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
	$display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module tb;
	localparam int BC = 16;
	logic clk, reset, avs_read, avs_write, txd, tx_en, irq, sp_en, rxd, avs_waitrequest;
	logic [4:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rdat;
	int bad_count = 0;
	int comparisons = 0;
	csl_link #(.BIT_CYC_2400(BC)) DUT (.CLK(clk), .RESET(reset), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
		.RXD(rxd), .TXD(txd), .TX_EN(tx_en), .IRQ(irq), .SETPOINT_WR_EN(sp_en));
	csl_host host (.CLK(clk), .TXD(txd), .TX_EN(tx_en), .RXD(rxd));
	// ----------------------------------------
	// bus and line tasks
	// ----------------------------------------
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++n < 60000);
		if (n >= 60000) bad_count++;
		rdat = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic rd(input logic [4:0] a);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd
	task automatic cfg(input logic [1:0] baud, input logic d8, input logic [1:0] par, input logic sp);
		bus(1'b1, csl_pkg::OFS_CTRL, {16'h0000, 8'h01, 2'h0, sp, par, d8, baud});
	endtask : cfg
	function automatic int bcyc(input int b);
		return b == 0 ? BC : b == 1 ? csl_pkg::CYC_4800 : b == 2 ? csl_pkg::CYC_9600 : csl_pkg::CYC_19200;
	endfunction : bcyc
	// send one character from the counter and check its frame on the wire
	task automatic tx_check(input logic [7:0] d, input int nd, input logic [1:0] par, input int bc);
		logic [11:0] bits;
		logic [7:0] dm, got;
		int nb, len;
		dm = (nd == 8) ? d : {1'b0, d[6:0]};
		got = 8'h00;
		nb = 2 + nd + ((par == 2'h1 || par == 2'h2) ? 1 : 0);
		bus(1'b1, csl_pkg::OFS_TXDATA, {24'h000000, d});
		host.recv(nb, bc, bits, len);
		for (int k = 0; k < nd; k++) got[k] = bits[k + 1];
		`CHK(bits[0], 1'b0)
		`CHK(got, dm)
		if (nb == nd + 3) `CHK(bits[nd + 1], (^dm) ^ (par == 2'h1))
		`CHK(bits[nb - 1], 1'b1)
		`CHK(len >= nb * bc - 2 && len <= nb * bc + 2, 1'b1)
	endtask : tx_check
	task automatic tx_str(input string s);
		for (int i = 0; i < s.len(); i++) tx_check(s[i], 7, 2'h0, BC);
	endtask : tx_str
	task automatic rx_str(input string s);
		for (int i = 0; i < s.len(); i++) host.send(s[i], 7, 2'h0, BC, 1'b0, 1'b0);
	endtask : rx_str
	task automatic complete_run();
		if (bad_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : complete_run
	// ----------------------------------------
	// clock, watchdog and test sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// cut a hung run short
	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		complete_run();
	end
	// main sequence
	initial begin
		{reset, avs_read, avs_write} = 3'b100;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rd(csl_pkg::OFS_CTRL); `CHK(rdat[15:0], csl_pkg::CTRL_RST)
		rd(csl_pkg::OFS_MASK); `CHK(rdat[5:0], 6'h00)
		rd(csl_pkg::OFS_RESP); `CHK(rdat[15:0], 16'h3030)
		rd(5'h1C); `CHK(rdat, 32'h0)
		`CHK({txd, tx_en, irq, sp_en}, 4'b1000)
		cfg(2'h0, 1'b0, 2'h0, 1'b1); @(negedge clk); `CHK(sp_en, 1'b1)
		cfg(2'h0, 1'b0, 2'h0, 1'b0); @(negedge clk); `CHK(sp_en, 1'b0)
		for (int b = 0; b < 4; b++) begin
			cfg(b[1:0], 1'b1, 2'h0, 1'b0);
			tx_check(8'hA5, 8, 2'h0, bcyc(b));
		end
		for (int m = 0; m < 8; m++) begin
			cfg(2'h0, m[2], m[1:0], 1'b0);
			tx_check(8'hD3, m[2] ? 8 : 7, m[1:0], BC);
		end
		bus(1'b1, csl_pkg::OFS_MASK, 32'h2); @(negedge clk); `CHK(irq, 1'b1)
		bus(1'b1, csl_pkg::OFS_MASK, 32'h0); @(negedge clk); `CHK(irq, 1'b0)
		bus(1'b1, csl_pkg::OFS_STAT, 32'h3F); rd(csl_pkg::OFS_STAT); `CHK(rdat[5:0], 6'h00)
		cfg(2'h0, 1'b0, 2'h0, 1'b0);
		tx_str("@01RD1");
		rd(csl_pkg::OFS_CKSUM); `CHK(rdat[15:0], 16'h3638)
		rx_str("@01RD1");
		rd(csl_pkg::OFS_RXDATA); `CHK(rdat[7:0], 8'h31)
		rd(csl_pkg::OFS_CKSUM); `CHK(rdat[31:16], 16'h3638)
		rx_str("68\r");
		rd(csl_pkg::OFS_STAT); `CHK(rdat[5:4], 2'b01)
		rd(csl_pkg::OFS_RESP); `CHK(rdat[15:0], 16'h3030)
		bus(1'b1, csl_pkg::OFS_STAT, 32'h3F);
		rx_str("@01RD169\r");
		rd(csl_pkg::OFS_STAT); `CHK(rdat[5:4], 2'b10)
		rd(csl_pkg::OFS_RESP); `CHK(rdat[15:0], 16'h3031)
		rx_str("@");
		rd(csl_pkg::OFS_RESP); `CHK(rdat[15:0], 16'h3030)
		cfg(2'h0, 1'b1, 2'h2, 1'b0);
		bus(1'b1, csl_pkg::OFS_STAT, 32'h3F);
		host.send(8'h55, 8, 2'h2, BC, 1'b1, 1'b0);
		rd(csl_pkg::OFS_STAT); `CHK(rdat[3:2], 2'b10)
		rd(csl_pkg::OFS_RESP); `CHK(rdat[15:0], 16'h3031)
		bus(1'b1, csl_pkg::OFS_STAT, 32'h3F);
		host.send(8'h55, 8, 2'h2, BC, 1'b0, 1'b1);
		rd(csl_pkg::OFS_STAT); `CHK(rdat[2], 1'b1)
		cfg(2'h0, 1'b1, 2'h0, 1'b0);
		fork
			host.send(8'h3C, 8, 2'h0, BC, 1'b0, 1'b0);
			begin
				repeat (20) @(posedge clk);
				tx_check(8'hC3, 8, 2'h0, BC);
			end
		join
		`CHK(host.overlap, 1'b0)
		rd(csl_pkg::OFS_RXDATA); `CHK(rdat[7:0], 8'h3C)
		complete_run();
	end
endmodule : tb
